// file: design/smpc_pkg.sv
// Package of constants and carrier types for the stop-mode peripheral controller
// Notes on behaviour
// - Any stop gates all peripheral clocks off.
// - Debug stay-awake keeps debug clock, peripherals halted.
// - Stop3 leaves pins driven by retained logic.
// - Stop2 latches pin states before stop.
// - Stop1 forces pins to reset state.
// - Stop3 keeps RAM and registers intact.
// - Stop2 wake resets registers, pins held until ack.
// - Stop1 wake resets registers, RAM not kept.
// - Stop3 clock generator standby, keep-running bits honoured.
// - Stop2/stop1 clock generator fully off.
// - Timers halt in stop, reset after deep wake.
// - Converter standby, no conversion, reset after deep wake.
// - Keypad pins wake device from stop3.
// - Keypad disabled in deep stop, reset after.
// - Serial units halt in stop, reset after deep wake.
// - SPI halts in stop, reset after deep wake.
// - I2C halts in stop, reset after deep wake.
// - Regulator standby unless voltage detect or debug.
// - Stop2 wake sets flag until ack written.
// - Debug stay-awake demotes deep stop to stop3.
// - Voltage detect in stop demotes deep stop to stop3.
package smpc_pkg;

    // ****************************************
    // Depths and states
    // ****************************************
    typedef enum logic [1:0] {
        SMPC_DEPTH_STOP3 = 2'h0,
        SMPC_DEPTH_STOP2 = 2'h1,
        SMPC_DEPTH_STOP1 = 2'h2
    } smpc_depth_t;

    typedef enum logic [2:0] {
        SMPC_RUN,
        SMPC_ENTER,
        SMPC_STOPPED,
        SMPC_WAKE_RESET,
        SMPC_WAKE
    } smpc_state_t;

    // ****************************************
    // Counts
    // ****************************************
    localparam int SMPC_WAKE_RESET_CYCLES = 4;
    localparam int SMPC_CNT_W             = 3;
    localparam int SMPC_NUM_PINS          = 38;
    localparam logic [SMPC_NUM_PINS-1:0] SMPC_PIN_RESET_VALUE = '0;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic timer_pwm_unit;
        logic analog_converter;
        logic keypad_interrupt;
        logic async_serial_unit;
        logic spi_unit;
        logic i2c_unit;
    } smpc_periph_t;

    typedef struct packed {
        logic osc_keep_running;
        logic ref_keep_running;
    } smpc_clkgen_cfg_t;

    typedef struct packed {
        logic osc_run;
        logic ref_run;
        logic standby;
        logic off;
    } smpc_clkgen_ctl_t;

endpackage : smpc_pkg

// file: design/smpc_pin_hold.sv
// Pin hold latch bank for partial powerdown
module smpc_pin_hold #(
    parameter int WIDTH = smpc_pkg::SMPC_NUM_PINS
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             capture,
    input  wire logic             force_default,
    input  wire logic             release_hold,
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] default_value,
    output logic      [WIDTH-1:0] pin_out,
    output logic                  holding
);
    import smpc_pkg::*;

    logic [WIDTH-1:0] held;
    wire  logic       next_holding;

    // Hold survives wake resets: only release or power-on reset opens it
    assign next_holding = capture | force_default | (holding & ~release_hold);
    assign pin_out      = holding ? held : pin_in;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            holding <= 1'b0;
        end else begin
            holding <= next_holding;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held <= '0;
        end else if (force_default) begin
            held <= default_value;
        end else if (capture) begin
            held <= pin_in;
        end
    end

endmodule : smpc_pin_hold

// file: design/smpc_top.sv
// Stop-mode sequencer: clock gating, pin hold, wake resets and standby controls
module smpc_top (
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic                              stop_instr,
    input  wire smpc_pkg::smpc_depth_t             stop_depth_cfg,
    input  wire logic                              debug_stay_awake_enable,
    input  wire logic                              lvd_in_stop_enable,
    input  wire smpc_pkg::smpc_clkgen_cfg_t        clkgen_cfg,
    input  wire logic                              wake_request,
    input  wire logic [7:0]                        keypad_pin_enable,
    input  wire logic [7:0]                        keypad_pin_level,
    input  wire logic                              partial_powerdown_ack,
    input  wire logic [smpc_pkg::SMPC_NUM_PINS-1:0] pin_drive_in,
    output logic      [smpc_pkg::SMPC_NUM_PINS-1:0] pin_drive_out,
    output logic                                   pin_hold_active,
    output smpc_pkg::smpc_periph_t                 periph_clk_en,
    output smpc_pkg::smpc_periph_t                 periph_reset,
    output logic                                   debug_clk_en,
    output logic                                   core_reset,
    output logic                                   ram_retain,
    output logic                                   ram_valid,
    output smpc_pkg::smpc_clkgen_ctl_t             clkgen_ctl,
    output logic                                   regulator_standby,
    output logic                                   converter_standby,
    output logic                                   converter_start_allow,
    output logic                                   keypad_wake_enable,
    output logic                                   partial_powerdown_flag,
    output logic                                   stopped,
    output smpc_pkg::smpc_depth_t                  active_depth
);
    import smpc_pkg::*;

    // ****************************************
    // Depth selection
    // ****************************************
    smpc_state_t           state;
    smpc_state_t           next_state;
    logic [SMPC_CNT_W-1:0] wake_cnt;
    logic                  lvd_latched;
    logic                  dbg_latched;
    logic                  ram_ok;

    wire logic        deep_blocked;
    wire smpc_depth_t chosen_depth;
    wire logic        in_stop;
    wire logic        is_stop3;
    wire logic        is_deep;
    wire logic        keypad_hit;
    wire logic        wake_now;
    wire logic        cnt_done;

    assign deep_blocked = debug_stay_awake_enable | lvd_in_stop_enable;
    assign chosen_depth = deep_blocked ? SMPC_DEPTH_STOP3 : stop_depth_cfg;

    assign in_stop  = (state == SMPC_ENTER) || (state == SMPC_STOPPED);
    assign is_stop3 = (active_depth == SMPC_DEPTH_STOP3);
    assign is_deep  = !is_stop3;

    assign keypad_hit = |(keypad_pin_enable & keypad_pin_level);
    assign wake_now   = wake_request | (is_stop3 & keypad_hit);
    assign cnt_done   = (wake_cnt == SMPC_CNT_W'(SMPC_WAKE_RESET_CYCLES - 1));

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            SMPC_RUN: begin
                if (stop_instr) begin
                    next_state = SMPC_ENTER;
                end
            end
            SMPC_ENTER: begin
                next_state = SMPC_STOPPED;
            end
            SMPC_STOPPED: begin
                if (wake_now) begin
                    next_state = is_deep ? SMPC_WAKE_RESET : SMPC_WAKE;
                end
            end
            SMPC_WAKE_RESET: begin
                if (cnt_done) begin
                    next_state = SMPC_WAKE;
                end
            end
            SMPC_WAKE: begin
                next_state = SMPC_RUN;
            end
            default: begin
                next_state = SMPC_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= SMPC_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Depth, voltage-detect and debug settings are sampled once, at the stop instruction; clkgen_cfg is read live
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            active_depth <= SMPC_DEPTH_STOP3;
            lvd_latched  <= 1'b0;
            dbg_latched  <= 1'b0;
        end else if (state == SMPC_RUN && stop_instr) begin
            active_depth <= chosen_depth;
            lvd_latched  <= lvd_in_stop_enable;
            dbg_latched  <= debug_stay_awake_enable;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || state != SMPC_WAKE_RESET) begin
            wake_cnt <= '0;
        end else begin
            wake_cnt <= wake_cnt + SMPC_CNT_W'(1);
        end
    end

    // ****************************************
    // Pin hold
    // ****************************************
    wire logic hold_capture;
    wire logic hold_force;

    // Stop3 keeps pins on live logic; deeper depths latch or default them
    assign hold_capture = (state == SMPC_ENTER) && (active_depth == SMPC_DEPTH_STOP2);
    assign hold_force   = (state == SMPC_ENTER) && (active_depth == SMPC_DEPTH_STOP1);

    smpc_pin_hold #(
        .WIDTH (SMPC_NUM_PINS)
    ) u_pin_hold (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .capture       (hold_capture),
        .force_default (hold_force),
        .release_hold  (partial_powerdown_ack && state == SMPC_RUN),
        .pin_in        (pin_drive_in),
        .default_value (SMPC_PIN_RESET_VALUE),
        .pin_out       (pin_drive_out),
        .holding       (pin_hold_active)
    );

    // ****************************************
    // Partial powerdown flag
    // ****************************************
    wire logic ppd_set;
    assign ppd_set = (state == SMPC_WAKE) && (active_depth == SMPC_DEPTH_STOP2);

    // Set wins over a same-cycle acknowledge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            partial_powerdown_flag <= 1'b0;
        end else if (ppd_set) begin
            partial_powerdown_flag <= 1'b1;
        end else if (partial_powerdown_ack) begin
            partial_powerdown_flag <= 1'b0;
        end
    end

    // RAM is lost by stop1 and marked good again in the wake state after the wake reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ram_ok <= 1'b1;
        end else if (hold_force) begin
            ram_ok <= 1'b0;
        end else if (state == SMPC_WAKE) begin
            ram_ok <= 1'b1;
        end
    end

    // ****************************************
    // Gating, resets and standby
    // ****************************************
    wire logic deep_wake_reset;
    assign deep_wake_reset = (state == SMPC_WAKE_RESET);

    assign periph_clk_en = in_stop ? '0 : '1;
    assign periph_reset  = deep_wake_reset ? '1 : '0;
    assign debug_clk_en  = !in_stop || dbg_latched;
    assign core_reset    = deep_wake_reset;
    assign ram_retain    = !(in_stop && active_depth == SMPC_DEPTH_STOP1);
    assign ram_valid     = ram_ok;

    wire logic osc_on;
    wire logic ref_on;
    assign osc_on = !in_stop || (is_stop3 && clkgen_cfg.osc_keep_running);
    assign ref_on = !in_stop || (is_stop3 && clkgen_cfg.ref_keep_running);
    assign clkgen_ctl = {osc_on, ref_on, in_stop && is_stop3, in_stop && is_deep};

    assign regulator_standby     = in_stop && !lvd_latched && !dbg_latched;
    assign converter_standby     = in_stop;
    assign converter_start_allow = !in_stop && !deep_wake_reset;
    assign keypad_wake_enable    = in_stop && is_stop3;
    assign stopped               = in_stop;

endmodule : smpc_top

// file: sim/smpc_core_model.sv
// Core model: issues the stop instruction and the wake source
module smpc_core_model (
    input  wire logic ref_clk,
    input  wire logic req_stop,
    input  wire logic req_wake,
    output logic      stop_instr   = 1'b0,
    output logic      wake_request = 1'b0
);
    // ********************
    // Core side
    // ********************
    always_ff @(posedge ref_clk) begin
        stop_instr   <= req_stop;
        wake_request <= req_wake;
    end
endmodule : smpc_core_model

// file: sim/smpc_assertions.sv
// Checker of stop entry, gating and wake resets
module smpc_assertions (
    input wire logic                       ref_clk,
    input wire logic                       reset,
    input wire logic                       stop_instr,
    input wire logic                       debug_stay_awake_enable,
    input wire logic                       lvd_in_stop_enable,
    input wire logic                       partial_powerdown_ack,
    input wire logic                       stopped,
    input wire smpc_pkg::smpc_periph_t     periph_clk_en,
    input wire smpc_pkg::smpc_periph_t     periph_reset,
    input wire logic                       core_reset,
    input wire smpc_pkg::smpc_clkgen_ctl_t clkgen_ctl,
    input wire logic                       regulator_standby,
    input wire logic                       converter_start_allow,
    input wire logic                       keypad_wake_enable,
    input wire logic                       partial_powerdown_flag,
    input wire smpc_pkg::smpc_depth_t      active_depth
);
    import smpc_pkg::*;
    // ********************
    // Properties
    // ********************
    wire deep = active_depth != SMPC_DEPTH_STOP3;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    AST_CLK_GATE: assert property (stopped |-> periph_clk_en == '0)
        else $error("peripheral clock on while stopped");
    AST_CLKGEN_OFF: assert property (stopped && deep |-> clkgen_ctl == 4'h1)
        else $error("clock generator not off in deep stop");
    AST_DEMOTE: assert property ($rose(stopped) && ($past(debug_stay_awake_enable)
        || $past(lvd_in_stop_enable)) |-> !deep) else $error("deep stop not demoted");
    AST_REG_STBY: assert property ($rose(stopped) |-> regulator_standby ==
        !($past(debug_stay_awake_enable) || $past(lvd_in_stop_enable)))
        else $error("regulator standby wrong");
    AST_STOP_CAUSE: assert property ($rose(stopped) |-> $past(stop_instr))
        else $error("stop entered without stop instruction");
    AST_WAKE_RST: assert property ($rose(core_reset) |-> core_reset[*4] ##1 !core_reset)
        else $error("wake reset length wrong");
    AST_PERIPH_RST: assert property (core_reset |-> periph_reset == '1)
        else $error("peripheral not reset on wake");
    AST_NO_CONV: assert property (stopped |-> !converter_start_allow)
        else $error("conversion allowed while stopped");
    AST_KEYPAD: assert property (stopped && deep |-> !keypad_wake_enable)
        else $error("keypad wake active in deep stop");
    AST_FLAG: assert property (partial_powerdown_flag && !partial_powerdown_ack
        |=> partial_powerdown_flag) else $error("flag dropped without ack");
endmodule : smpc_assertions
bind smpc_top smpc_assertions smpc_assertions_i (.ref_clk, .reset, .stop_instr,
    .debug_stay_awake_enable, .lvd_in_stop_enable, .partial_powerdown_ack, .stopped,
    .periph_clk_en, .periph_reset, .core_reset, .clkgen_ctl, .regulator_standby,
    .converter_start_allow, .keypad_wake_enable, .partial_powerdown_flag, .active_depth);

// file: sim/smpc_tb_top.sv
// Self-checking bench of the stop-mode controller
module smpc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import smpc_pkg::*;
    localparam logic [37:0] PA = 38'h2A_AAAA_AAAA;
    localparam logic [37:0] PB = 38'h15_5555_5555;
    logic ref_clk = 1'b0, reset = 1'b1, req_stop = 1'b0, req_wake = 1'b0;
    logic dbg = 1'b0, low_voltage_detect = 1'b0, ack = 1'b0;
    logic [7:0] kp_lvl = 8'h00;
    logic [37:0] pins = PA, pout;
    smpc_depth_t depth = SMPC_DEPTH_STOP3, adepth;
    logic stop_instr, wake_request, hold, dclk, crst, rret, rval, rstby, cstby, kwake, flag, stopped;
    smpc_periph_t pclk, prst;
    logic cstart;
    smpc_clkgen_cfg_t kcfg = 2'h3;
    smpc_clkgen_ctl_t cctl;
    int miscompares = 0, check_count = 0;
    smpc_core_model smpc_core_model_i (.ref_clk, .req_stop, .req_wake, .stop_instr, .wake_request);
    smpc_top smpc_top_i (.ref_clk, .reset, .stop_instr, .stop_depth_cfg(depth),
        .debug_stay_awake_enable(dbg), .lvd_in_stop_enable(low_voltage_detect), .clkgen_cfg(kcfg),
        .wake_request, .keypad_pin_enable(8'h04), .keypad_pin_level(kp_lvl),
        .partial_powerdown_ack(ack), .pin_drive_in(pins), .pin_drive_out(pout),
        .pin_hold_active(hold), .periph_clk_en(pclk), .periph_reset(prst), .debug_clk_en(dclk),
        .core_reset(crst), .ram_retain(rret), .ram_valid(rval), .clkgen_ctl(cctl),
        .regulator_standby(rstby), .converter_standby(cstby), .converter_start_allow(cstart),
        .keypad_wake_enable(kwake), .partial_powerdown_flag(flag), .stopped, .active_depth(adepth));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // ********************
    // Helpers
    // ********************
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic wait_stop(input logic v);
        int n;
        n = 0;
        while (stopped !== v && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (stopped !== v) begin
            miscompares++;
            print_verdict();
        end
    endtask : wait_stop
    task automatic enter(input smpc_depth_t d, input logic b, input logic l, input logic [37:0] p);
        @(posedge ref_clk);
        depth <= d;
        dbg <= b;
        low_voltage_detect <= l;
        pins <= p;
        req_stop <= 1'b1;
        @(posedge ref_clk);
        req_stop <= 1'b0;
        wait_stop(1'b1);
        @(posedge ref_clk);
        pins <= PB;
        @(posedge ref_clk);
        #1;
    endtask : enter
    task automatic leave(input logic kp);
        @(posedge ref_clk);
        if (kp)
            kp_lvl <= 8'h04;
        else
            req_wake <= 1'b1;
        wait_stop(1'b0);
        chk("wake_rst", {crst, prst, cstart}, kp ? 8'h01 : 8'hFE);
        @(posedge ref_clk);
        kp_lvl <= 8'h00;
        req_wake <= 1'b0;
        repeat (7) @(posedge ref_clk);
        #1;
    endtask : leave
    task automatic ack_pulse();
        @(posedge ref_clk);
        ack <= 1'b1;
        @(posedge ref_clk);
        ack <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("flag", flag, 1'b0);
        chk("hold", hold, 1'b0);
        chk("pins", pout, PB);
    endtask : ack_pulse
    task automatic kp_try(input logic [7:0] lvl);
        @(posedge ref_clk);
        kp_lvl <= lvl;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("kp_ignored", stopped, 1'b1);
    endtask : kp_try
    // ********************
    // Scenarios
    // ********************
    task automatic sc_stop3();
        enter(SMPC_DEPTH_STOP3, 1'b0, 1'b0, PA);
        chk("clk_en", pclk, 6'h00);
        chk("pins", pout, PB);
        chk("clkgen", cctl, 4'hE);
        chk("ram", {rret, rval}, 2'h3);
        chk("kwake", kwake, 1'b1);
        chk("stby", {rstby, cstby, dclk}, 3'h6);
        leave(1'b1);
        chk("crst", {crst, flag, hold}, 3'h0);
        @(posedge ref_clk);
        kcfg <= 2'h1;
        enter(SMPC_DEPTH_STOP3, 1'b0, 1'b0, PA);
        chk("clkgen", cctl, 4'h6);
        kp_try(8'hFB);
        leave(1'b1);
        @(posedge ref_clk);
        kcfg <= 2'h3;
    endtask : sc_stop3
    task automatic sc_stop2();
        enter(SMPC_DEPTH_STOP2, 1'b0, 1'b0, PA);
        chk("pins", pout, PA);
        chk("clkgen", cctl, 4'h1);
        chk("kwake", kwake, 1'b0);
        kp_try(8'h04);
        leave(1'b0);
        chk("flag", flag, 1'b1);
        chk("pins", pout, PA);
        ack_pulse();
    endtask : sc_stop2
    task automatic sc_stop1();
        enter(SMPC_DEPTH_STOP1, 1'b0, 1'b0, PA);
        chk("pins", pout, SMPC_PIN_RESET_VALUE);
        chk("ram", {rret, rval}, 2'h0);
        chk("clkgen", cctl, 4'h1);
        leave(1'b0);
        chk("flag", flag, 1'b0);
        chk("ram_after", {rret, rval}, 2'h3);
        ack_pulse();
    endtask : sc_stop1
    task automatic sc_demote();
        for (int i = 0; i < 2; i++) begin
            enter(SMPC_DEPTH_STOP2, i == 0, i == 1, PA);
            chk("depth", adepth, SMPC_DEPTH_STOP3);
            chk("rstby", rstby, 1'b0);
            chk("dclk", dclk, i == 0);
            chk("clk_en", pclk, 6'h00);
            chk("pins", {hold, pout}, {1'b0, PB});
            leave(1'b1);
            chk("flag", flag, 1'b0);
        end
    endtask : sc_demote
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        sc_stop3();
        sc_stop2();
        sc_stop1();
        sc_demote();
        print_verdict();
    end
endmodule : smpc_tb_top
